// >>> rtl/spai_consts.vh
// Register offsets, field positions and codes for the serial-port auxiliary interrupt logic
`ifndef SPAI_CONSTS_VH
`define SPAI_CONSTS_VH
// Register addresses
`define SPAI_ADDR_CTRL      8'h9A
`define SPAI_ADDR_DATA      8'h9B
`define SPAI_ADDR_POLL      8'hA4
`define SPAI_ADDR_PEND      8'hA5
`define SPAI_ADDR_MASK      8'hA6
`define SPAI_ADDR_CIE       8'hA8
`define SPAI_ADDR_SECOND_TIMER_IRQ_REGISTER    8'hF9
`define SPAI_ADDR_MILLISECOND_TIMER_IRQ_REGISTER     8'hFA
`define SPAI_ADDR_SUMLO     8'hE2
`define SPAI_ADDR_ADCLO     8'hD9
`define SPAI_ADDR_EXTCTL    8'hD8
// Control field positions
`define SPAI_B_STOP         3
`define SPAI_B_START        2
`define SPAI_B_DCS          1
`define SPAI_B_CSEL         0
`define SPAI_B_ORDER        3
`define SPAI_B_CLOCK_PHASE_SELECT         2
`define SPAI_B_SSEN         1
`define SPAI_B_CLOCK_IDLE_LEVEL         0
`define SPAI_B_AUXEN        4
`define SPAI_B_GEN          7
// Auxiliary source bit positions
`define SPAI_S_SEC          7
`define SPAI_S_SUM          6
`define SPAI_S_ADC          5
`define SPAI_S_MSEC         4
`define SPAI_S_TWI          3
`define SPAI_S_CNT          2
`define SPAI_S_ALV          1
// Pending index codes
`define SPAI_P_NONE         4'h0
`define SPAI_P_ALV          4'h2
`define SPAI_P_TWI          4'h3
`define SPAI_P_CNT          4'h4
`define SPAI_P_MSEC         4'h5
`define SPAI_P_ADC          4'h6
`define SPAI_P_SUM          4'h7
`define SPAI_P_SEC          4'h8
// Bit counts, reset value and writable-bit masks
`define SPAI_CNT_FULL       4'h8
`define SPAI_CNT_ONE        4'h1
`define SPAI_RST_BYTE       8'h00
`define SPAI_MASK_VALID     8'hFE
`define SPAI_CIE_VALID      8'h9F
`endif

// >>> rtl/spai_top.v
// Serial-port control and auxiliary interrupt logic of the core
// Notes on behaviour
// - Bit count reported in gray-like 4-bit code
// - Bit order bit picks MSB or LSB first
// - Phase bit clear presents data half period early
// - Slave select gates data output drive
// - Polarity bit sets serial clock idle level
// - Stop sets stop flag; data write clears
// - Start sets start flag; data write clears
// - Stretch unless disabled; start clears disable
// - Count interrupt at eight or one bits
// - Separate transmit and receive buffers, one address
// - SPI read clears rx, write clears tx
// - Poll register shows raw source states
// - Pending index names highest priority source
// - Index code one never produced
// - Mask bits 7 to 1 writable; mask offset reads back masked status
// - Status flag is active and unmasked
// - Timer and summation flags clear on reads
// - ADC flag clears on read, blocks results
// - Start/stop clears on write; count on access
// - Low-voltage flag follows the detector
// - Global enable gates standard interrupts only
// - Each standard interrupt needs its enable
// - Auxiliary interrupt needs extended enable bit
// - Serial interrupt from receive or transmit flag
`include "spai_consts.vh"
module spai_top
(
   input  wire       clk,               // System clock
   input  wire       rst,               // Synchronous reset, active high
   input  wire [7:0] sfr_addr,          // Special-function register address
   input  wire       sfr_wr,            // Write strobe
   input  wire       sfr_rd,            // Read strobe
   input  wire [7:0] sfr_wdata,         // Write data
   output reg  [7:0] sfr_rdata,         // Read data, registered
   input  wire       spi_mode,          // 1 when the port runs SPI, 0 two-wire
   input  wire       bit_tick,          // One-cycle pulse per bit shifted
   input  wire       frame_start,       // One-cycle pulse, new byte begins
   input  wire       ser_in_bit,        // Received bit, same clock domain
   input  wire       sclk_active,       // Serial clock level before idle mapping
   input  wire       sclk_edge,         // Serial clock first-edge pulse
   input  wire       twi_start_det,     // Start or repeated start seen
   input  wire       twi_stop_det,      // Stop condition seen
   input  wire       spi_rx_done,       // SPI byte received pulse
   input  wire       spi_tx_done,       // SPI byte sent pulse
   input  wire       slave_sel_pin,     // Slave-select pin, asynchronous
   input  wire       sec_evt,           // Second timer event pulse
   input  wire       msec_evt,          // Millisecond timer event pulse
   input  wire       sum_evt,           // Accumulator event pulse
   input  wire       adc_evt,           // Conversion done pulse
   input  wire       low_voltage_status,// Detector reports supply low
   input  wire       serial0_receive_flag,
   input  wire       serial0_transmit_flag,
   input  wire       timer1_overflow_flag,
   input  wire       timer0_overflow_flag,
   input  wire       ext_pin1_req,      // External pin 1 request
   input  wire       ext_pin0_req,      // External pin 0 request
   output reg        ser_out_bit,       // Serial data output value
   output wire       ser_out_oe_n,      // Data output enable, low drives
   output wire       sclk_out,          // Serial clock after polarity
   output wire       stretch_en,        // Two-wire clock stretch enable
   output wire       ss_as_gpio,        // Slave-select pin left as general I/O
   output wire       adc_result_block,  // Blocks new results while flag set
   output wire       spi_rx_irq,        // SPI receive interrupt
   output wire       spi_tx_irq,        // SPI transmit interrupt
   output wire [4:0] core_irq_req,      // Gated standard interrupts
   output wire       aux_irq_req        // Auxiliary interrupt to core
);
   // Control registers
   reg  [3:0] cnt_r;                    // Binary bit count
   reg        order_r;                  // Bit order
   reg        clock_phase_select_r;                   // Clock phase
   reg        ssen_r;                   // Slave select enable
   reg        clock_idle_level_r;                   // Clock idle level
   reg        stop_r;                   // Stop status
   reg        start_r;                  // Start status
   reg        dcs_r;                    // Stretch disable
   reg        csel_r;                   // Count interrupt select
   reg  [7:0] tx_buf_r;                 // Transmit buffer
   reg  [7:0] rx_buf_r;                 // Receive buffer
   reg  [7:0] tx_sh_r;                  // Transmit shifter
   reg  [7:0] rx_sh_r;                  // Receive shifter
   reg        rxi_r;                    // SPI receive interrupt flag
   reg        txi_r;                    // SPI transmit interrupt flag
   reg  [7:0] raw_r;                    // Raw auxiliary sources
   reg  [7:0] mask_r;                   // Auxiliary mask
   reg  [7:0] cie_r;                    // Core interrupt enable
   reg        auxen_r;                  // Extended auxiliary enable
   reg  [3:0] pend_r;                   // Pending index
   reg        ss_s1_r;                  // Slave-select synchroniser stage 1
   reg        ss_s2_r;                  // Slave-select synchroniser stage 2
   wire [7:0] stat_w;                   // Masked status
   wire       wr_data;                  // Data register write
   wire       rd_data;                  // Data register read
   reg  [3:0] pend_nxt;                 // Next pending index
   reg  [7:0] rdata_nxt;                // Next read data

   // Bit count to reported code
   function [3:0] cnt_code;
      input [3:0] c;
      begin
         case (c)
            4'h0:    cnt_code = 4'h0;
            4'h1:    cnt_code = 4'h1;
            4'h2:    cnt_code = 4'h3;
            4'h3:    cnt_code = 4'h2;
            4'h4:    cnt_code = 4'h6;
            4'h5:    cnt_code = 4'h7;
            4'h6:    cnt_code = 4'h5;
            4'h7:    cnt_code = 4'h4;
            default: cnt_code = 4'hC;
         endcase
      end
   endfunction

   assign wr_data = sfr_wr && (sfr_addr == `SPAI_ADDR_DATA);
   assign rd_data = sfr_rd && (sfr_addr == `SPAI_ADDR_DATA);

   // Slave-select synchroniser
   always @(posedge clk)
   begin
      if (rst)
      begin
         ss_s1_r <= 1'b1;
         ss_s2_r <= 1'b1;
      end
      else
      begin
         ss_s1_r <= slave_sel_pin;
         ss_s2_r <= ss_s1_r;
      end
   end

   // Pin-facing outputs
   assign ser_out_oe_n = ssen_r & ss_s2_r;
   assign ss_as_gpio   = ~ssen_r;
   assign sclk_out     = sclk_active ^ clock_idle_level_r;
   assign stretch_en   = ~dcs_r;
   assign spi_rx_irq   = rxi_r;
   assign spi_tx_irq   = txi_r;

   // Shift datapath, bit counter and buffers
   always @(posedge clk)
   begin
      if (rst)
      begin
         cnt_r       <= 4'h0;
         tx_sh_r     <= `SPAI_RST_BYTE;
         rx_sh_r     <= `SPAI_RST_BYTE;
         rx_buf_r    <= `SPAI_RST_BYTE;
         ser_out_bit <= 1'b0;
      end
      else if (frame_start)
      begin
         // New byte: load shifter; present first bit when phase bit is clear
         cnt_r   <= 4'h0;
         tx_sh_r <= tx_buf_r;
         if (!clock_phase_select_r)
            // Data valid half a period before first edge
            ser_out_bit <= order_r ? tx_buf_r[0] : tx_buf_r[7];
      end
      else
      begin
         if (clock_phase_select_r && sclk_edge && cnt_r == 4'h0)
            // Data valid from the first edge
            ser_out_bit <= order_r ? tx_sh_r[0] : tx_sh_r[7];
         if (bit_tick && cnt_r != `SPAI_CNT_FULL)
         begin
            cnt_r <= cnt_r + 4'h1;
            // Shift out and in in chosen order
            if (order_r)
            begin
               tx_sh_r     <= {1'b0, tx_sh_r[7:1]};
               rx_sh_r     <= {ser_in_bit, rx_sh_r[7:1]};
               ser_out_bit <= tx_sh_r[1];
            end
            else
            begin
               tx_sh_r     <= {tx_sh_r[6:0], 1'b0};
               rx_sh_r     <= {rx_sh_r[6:0], ser_in_bit};
               ser_out_bit <= tx_sh_r[6];
            end
            if (cnt_r == `SPAI_CNT_FULL - 4'h1)
               // Byte complete: move to receive buffer
               rx_buf_r <= order_r ? {ser_in_bit, rx_sh_r[7:1]}
                                   : {rx_sh_r[6:0], ser_in_bit};
         end
      end
   end

   // Control, buffers and interrupt flags
   always @(posedge clk)
   begin
      if (rst)
      begin
         order_r  <= 1'b0;
         clock_phase_select_r   <= 1'b0;
         ssen_r   <= 1'b0;
         clock_idle_level_r   <= 1'b0;
         stop_r   <= 1'b0;
         start_r  <= 1'b0;
         dcs_r    <= 1'b0;
         csel_r   <= 1'b0;
         tx_buf_r <= `SPAI_RST_BYTE;
         rxi_r    <= 1'b0;
         txi_r    <= 1'b0;
         mask_r   <= `SPAI_RST_BYTE;
         cie_r    <= `SPAI_RST_BYTE;
         auxen_r  <= 1'b0;
      end
      else
      begin
         // Control register write; two-wire and SPI views share bits
         if (sfr_wr && sfr_addr == `SPAI_ADDR_CTRL)
         begin
            if (spi_mode)
            begin
               order_r <= sfr_wdata[`SPAI_B_ORDER];
               clock_phase_select_r  <= sfr_wdata[`SPAI_B_CLOCK_PHASE_SELECT];
               ssen_r  <= sfr_wdata[`SPAI_B_SSEN];
               clock_idle_level_r  <= sfr_wdata[`SPAI_B_CLOCK_IDLE_LEVEL];
            end
            else
            begin
               dcs_r  <= sfr_wdata[`SPAI_B_DCS];
               csel_r <= sfr_wdata[`SPAI_B_CSEL];
            end
         end
         // Start condition clears stretch disable, wins over write
         if (twi_start_det)
            dcs_r <= 1'b0;
         if (wr_data)
            tx_buf_r <= sfr_wdata;
         // Start/stop status: set wins over data-write clear
         if (twi_stop_det)
            stop_r <= 1'b1;
         else if (wr_data)
            stop_r <= 1'b0;
         if (twi_start_det)
            start_r <= 1'b1;
         else if (wr_data)
            start_r <= 1'b0;
         // SPI receive and transmit flags
         if (spi_rx_done)
            rxi_r <= 1'b1;
         else if (spi_mode && rd_data)
            rxi_r <= 1'b0;
         if (spi_tx_done)
            txi_r <= 1'b1;
         else if (spi_mode && wr_data)
            txi_r <= 1'b0;
         if (sfr_wr && sfr_addr == `SPAI_ADDR_MASK)
            mask_r <= sfr_wdata & `SPAI_MASK_VALID;
         if (sfr_wr && sfr_addr == `SPAI_ADDR_CIE)
            cie_r <= sfr_wdata & `SPAI_CIE_VALID;
         if (sfr_wr && sfr_addr == `SPAI_ADDR_EXTCTL)
            auxen_r <= sfr_wdata[`SPAI_B_AUXEN];
      end
   end

   // Raw auxiliary sources; each set wins over its clear
   always @(posedge clk)
   begin
      if (rst)
         raw_r <= `SPAI_RST_BYTE;
      else
      begin
         if (sec_evt)
            raw_r[`SPAI_S_SEC] <= 1'b1;
         else if (sfr_rd && sfr_addr == `SPAI_ADDR_SECOND_TIMER_IRQ_REGISTER)
            raw_r[`SPAI_S_SEC] <= 1'b0;
         if (msec_evt)
            raw_r[`SPAI_S_MSEC] <= 1'b1;
         else if (sfr_rd && sfr_addr == `SPAI_ADDR_MILLISECOND_TIMER_IRQ_REGISTER)
            raw_r[`SPAI_S_MSEC] <= 1'b0;
         if (sum_evt)
            raw_r[`SPAI_S_SUM] <= 1'b1;
         else if (sfr_rd && sfr_addr == `SPAI_ADDR_SUMLO)
            raw_r[`SPAI_S_SUM] <= 1'b0;
         if (adc_evt)
            raw_r[`SPAI_S_ADC] <= 1'b1;
         else if (sfr_rd && sfr_addr == `SPAI_ADDR_ADCLO)
            raw_r[`SPAI_S_ADC] <= 1'b0;
         if (twi_start_det || twi_stop_det)
            raw_r[`SPAI_S_TWI] <= 1'b1;
         else if (wr_data)
            raw_r[`SPAI_S_TWI] <= 1'b0;
         // Count interrupt at eight bits or at one bit
         if (bit_tick && !frame_start &&
             (cnt_r + 4'h1) == (csel_r ? `SPAI_CNT_ONE : `SPAI_CNT_FULL))
            raw_r[`SPAI_S_CNT] <= 1'b1;
         else if (wr_data || rd_data)
            raw_r[`SPAI_S_CNT] <= 1'b0;
         // Low-voltage flag follows detector, cleared by hardware
         raw_r[`SPAI_S_ALV] <= low_voltage_status;
         raw_r[0] <= 1'b0;
      end
   end

   assign stat_w           = raw_r & mask_r;
   assign adc_result_block = raw_r[`SPAI_S_ADC];
   assign aux_irq_req      = auxen_r & (pend_r != `SPAI_P_NONE);

   // Standard interrupt gating
   assign core_irq_req[4] = cie_r[`SPAI_B_GEN] & cie_r[4] &
                            (serial0_receive_flag | serial0_transmit_flag);
   assign core_irq_req[3] = cie_r[`SPAI_B_GEN] & cie_r[3] & timer1_overflow_flag;
   assign core_irq_req[2] = cie_r[`SPAI_B_GEN] & cie_r[2] & ext_pin1_req;
   assign core_irq_req[1] = cie_r[`SPAI_B_GEN] & cie_r[1] & timer0_overflow_flag;
   assign core_irq_req[0] = cie_r[`SPAI_B_GEN] & cie_r[0] & ext_pin0_req;

   // Priority encoder: lowest code among active sources
   always @*
   begin
      pend_nxt = `SPAI_P_NONE;
      if (stat_w[`SPAI_S_ALV])
         pend_nxt = `SPAI_P_ALV;
      else if (stat_w[`SPAI_S_TWI])
         pend_nxt = `SPAI_P_TWI;
      else if (stat_w[`SPAI_S_CNT])
         pend_nxt = `SPAI_P_CNT;
      else if (stat_w[`SPAI_S_MSEC])
         pend_nxt = `SPAI_P_MSEC;
      else if (stat_w[`SPAI_S_ADC])
         pend_nxt = `SPAI_P_ADC;
      else if (stat_w[`SPAI_S_SUM])
         pend_nxt = `SPAI_P_SUM;
      else if (stat_w[`SPAI_S_SEC])
         pend_nxt = `SPAI_P_SEC;
   end

   // Pending index register
   always @(posedge clk)
   begin
      if (rst)
         pend_r <= `SPAI_P_NONE;
      else
         pend_r <= pend_nxt;
   end

   // Read multiplexer; mask offset reads back status
   always @*
   begin
      rdata_nxt = `SPAI_RST_BYTE;
      case (sfr_addr)
         `SPAI_ADDR_CTRL:
            rdata_nxt = spi_mode ? {cnt_code(cnt_r), order_r, clock_phase_select_r, ssen_r, clock_idle_level_r}
                                 : {cnt_code(cnt_r), stop_r, start_r, dcs_r, csel_r};
         `SPAI_ADDR_DATA:   rdata_nxt = rx_buf_r;
         `SPAI_ADDR_POLL:   rdata_nxt = raw_r;
         `SPAI_ADDR_PEND:   rdata_nxt = {4'h0, pend_r};
         `SPAI_ADDR_MASK:   rdata_nxt = stat_w;
         `SPAI_ADDR_CIE:    rdata_nxt = cie_r;
         `SPAI_ADDR_EXTCTL: rdata_nxt = {3'b000, auxen_r, 4'h0};
         default:           rdata_nxt = `SPAI_RST_BYTE;
      endcase
   end

   // Registered read data
   always @(posedge clk)
   begin
      if (rst)
         sfr_rdata <= `SPAI_RST_BYTE;
      else if (sfr_rd)
         sfr_rdata <= rdata_nxt;
   end
endmodule // spai_top

// >>> tb/spai_top_props.sv
// Port-level assertions for the serial-port auxiliary interrupt logic
module spai_top_props
(
   input wire logic       clk,                   // System clock
   input wire logic       rst,                   // Synchronous reset
   input wire logic [7:0] sfr_addr,              // Register address
   input wire logic       sfr_rd,                // Read strobe
   input wire logic [7:0] sfr_rdata,             // Read data
   input wire logic       adc_evt,               // Conversion done pulse
   input wire logic       twi_start_det,         // Start condition pulse
   input wire logic       slave_sel_pin,         // Slave-select pin
   input wire logic       serial0_receive_flag,  // Serial receive flag
   input wire logic       serial0_transmit_flag, // Serial transmit flag
   input wire logic       timer1_overflow_flag,  // Timer 1 overflow flag
   input wire logic       ser_out_oe_n,          // Data output enable, low drives
   input wire logic       stretch_en,            // Clock stretch enable
   input wire logic       ss_as_gpio,            // Slave select left as general I/O
   input wire logic       adc_result_block,      // Result write block
   input wire logic [4:0] core_irq_req           // Gated standard interrupts
);
   timeunit 1ns;
   timeprecision 1ps;
   // All checks share the system clock and its reset
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   property p_pend_code;
      sfr_rd && sfr_addr == 8'hA5 |=> sfr_rdata[7:4] == 4'h0 && sfr_rdata[3:0] != 4'h1;
   endproperty
   a_pend_code: assert property (p_pend_code) else $error("bad pending index");
   property p_poll_low;
      sfr_rd && sfr_addr == 8'hA4 |=> !sfr_rdata[0];
   endproperty
   a_poll_low: assert property (p_poll_low) else $error("poll bit 0 set");
   property p_cie_gap;
      sfr_rd && sfr_addr == 8'hA8 |=> sfr_rdata[6:5] == 2'h0;
   endproperty
   a_cie_gap: assert property (p_cie_gap) else $error("enable gap bits set");
   property p_serial_src;
      core_irq_req[4] |-> serial0_receive_flag || serial0_transmit_flag;
   endproperty
   a_serial_src: assert property (p_serial_src) else $error("serial irq no flag");
   property p_timer1_src;
      core_irq_req[3] |-> timer1_overflow_flag;
   endproperty
   a_timer1_src: assert property (p_timer1_src) else $error("timer1 irq no flag");
   property p_adc_block;
      adc_evt |=> adc_result_block;
   endproperty
   a_adc_block: assert property (p_adc_block) else $error("result not blocked");
   property p_start_stretch;
      twi_start_det |=> stretch_en;
   endproperty
   a_start_stretch: assert property (p_start_stretch) else $error("stretch off");
   property p_ss_float;
      (!ss_as_gpio && slave_sel_pin) [*4] |-> ser_out_oe_n;
   endproperty
   a_ss_float: assert property (p_ss_float) else $error("output driven");
endmodule // spai_top_props

bind spai_top spai_top_props u_props
(
   .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
   .adc_evt(adc_evt), .twi_start_det(twi_start_det), .slave_sel_pin(slave_sel_pin),
   .serial0_receive_flag(serial0_receive_flag), .serial0_transmit_flag(serial0_transmit_flag),
   .timer1_overflow_flag(timer1_overflow_flag), .ser_out_oe_n(ser_out_oe_n),
   .stretch_en(stretch_en), .ss_as_gpio(ss_as_gpio), .adc_result_block(adc_result_block),
   .core_irq_req(core_irq_req)
);

// >>> tb/spai_core_model.sv
// Core model that reads and writes the special-function registers
module spai_core_model
(
   input  wire logic       clk,       // System clock
   input  wire logic [7:0] sfr_rdata, // Read data from the block
   output logic      [7:0] sfr_addr,  // Register address
   output logic            sfr_wr,    // Write strobe
   output logic            sfr_rd,    // Read strobe
   output logic      [7:0] sfr_wdata  // Write data
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle from time zero
   initial
   begin
      sfr_addr  = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr    = 1'b0;
      sfr_rd    = 1'b0;
   end
   // One write, strobe seen at a single rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(negedge clk);
      sfr_wr    = 1'b0;
   endtask
   // One read, data taken once the strobed edge has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(negedge clk);
      sfr_rd   = 1'b0;
      d        = sfr_rdata;
   endtask
endmodule // spai_core_model

// >>> tb/serial_port_aux_interrupt_logic_test.sv
// Self-checking testbench for the serial-port auxiliary interrupt logic
module serial_port_aux_interrupt_logic_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst;            // Clock and reset
   logic [7:0] sfr_addr, sfr_wdata; // Bus address and write data
   logic       sfr_wr, sfr_rd;      // Bus strobes
   wire  [7:0] sfr_rdata;           // Bus read data
   logic       spi_mode, ser_in;    // Port view and received bit
   logic       sclk_act, ss, lv, edg; // Clock level, slave select, supply low
   logic [5:0] fl;                  // Standard flags rx tx t1 t0 e1 e0
   logic [9:0] ev;                  // Event pulses
   wire        ser_out_bit, ser_out_oe_n, sclk_out, stretch_en, ss_as_gpio;
   wire        adc_result_block, spi_rx_irq, spi_tx_irq, aux_irq_req;
   wire  [4:0] core_irq_req;        // Gated standard interrupts
   int         mismatches, n_compared;
   logic [3:0] cnt_code [9] = '{4'h0, 4'h1, 4'h3, 4'h2, 4'h6, 4'h7, 4'h5, 4'h4, 4'hC};
   logic [7:0] rst_regs [6] = '{8'h9A, 8'h9B, 8'hA4, 8'hA5, 8'hA6, 8'hA8};

   spai_core_model core (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
   spai_top uut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .spi_mode(spi_mode), .bit_tick(ev[7]),
      .frame_start(ev[6]), .ser_in_bit(ser_in), .sclk_active(sclk_act), .sclk_edge(edg),
      .twi_start_det(ev[4]), .twi_stop_det(ev[5]), .spi_rx_done(ev[8]), .spi_tx_done(ev[9]),
      .slave_sel_pin(ss), .sec_evt(ev[0]), .msec_evt(ev[1]), .sum_evt(ev[2]), .adc_evt(ev[3]),
      .low_voltage_status(lv), .serial0_receive_flag(fl[5]), .serial0_transmit_flag(fl[4]),
      .timer1_overflow_flag(fl[3]), .timer0_overflow_flag(fl[2]), .ext_pin1_req(fl[1]),
      .ext_pin0_req(fl[0]), .ser_out_bit(ser_out_bit), .ser_out_oe_n(ser_out_oe_n),
      .sclk_out(sclk_out), .stretch_en(stretch_en), .ss_as_gpio(ss_as_gpio),
      .adc_result_block(adc_result_block), .spi_rx_irq(spi_rx_irq), .spi_tx_irq(spi_tx_irq),
      .core_irq_req(core_irq_req), .aux_irq_req(aux_irq_req));

   // Free-running 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Compare a byte, count and report
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // Compare a single output bit
   task automatic chb(input string n, input logic e, input logic g);
      chk(n, {7'h00, e}, {7'h00, g});
   endtask
   // Read a register and compare the bits under a mask
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] v;
      core.rd(a, v);
      chk($sformatf("reg %h", a), e, v & m);
   endtask
   // One-cycle event pulse
   task automatic pu(input logic [9:0] m);
      @(negedge clk);
      ev = m;
      @(negedge clk);
      ev = 10'h000;
   endtask
   // Reset values and read-only gaps
   task t_reset;
      foreach (rst_regs[i])
         rc(rst_regs[i], 8'hFF, 8'h00);
      core.wr(8'hA8, 8'hFF);
      rc(8'hA8, 8'hFF, 8'h9F);
      rc(8'h55, 8'hFF, 8'h00);
   endtask
   // Standard interrupt gating
   task t_core;
      core.wr(8'hA8, 8'h9F);
      fl = 6'h3F;
      @(negedge clk) chk("core_irq_req", 8'h1F, {3'h0, core_irq_req});
      fl = 6'h20;
      @(negedge clk) chk("core_irq_req", 8'h10, {3'h0, core_irq_req});
      fl = 6'h04;
      @(negedge clk) chk("core_irq_req", 8'h02, {3'h0, core_irq_req});
      fl = 6'h3F;
      core.wr(8'hA8, 8'h1F);
      chk("core_irq_req", 8'h00, {3'h0, core_irq_req});
      core.wr(8'hA8, 8'h90);
      fl = 6'h0F;
      @(negedge clk) chk("core_irq_req", 8'h00, {3'h0, core_irq_req});
      fl = 6'h10;
      @(negedge clk) chk("core_irq_req", 8'h10, {3'h0, core_irq_req});
      fl = 6'h00;
   endtask
   // Auxiliary poll, mask, status, pending index and clears
   task t_aux;
      core.wr(8'hA6, 8'hFE);
      core.wr(8'hD8, 8'h10);
      pu(10'h003);
      rc(8'hA4, 8'hFF, 8'h90);
      rc(8'hA6, 8'hFF, 8'h90);
      rc(8'hA5, 8'hFF, 8'h05);
      chb("aux_irq_req", 1'b1, aux_irq_req);
      rc(8'hFA, 8'hFF, 8'h00);
      rc(8'hA5, 8'hFF, 8'h08);
      rc(8'hF9, 8'hFF, 8'h00);
      rc(8'hA5, 8'hFF, 8'h00);
      core.wr(8'hD8, 8'h00);
      pu(10'h004);
      rc(8'hA5, 8'hFF, 8'h07);
      chb("aux_irq_req", 1'b0, aux_irq_req);
      rc(8'hE2, 8'hFF, 8'h00);
      rc(8'hA4, 8'hFF, 8'h00);
      core.wr(8'hA6, 8'h00);
      pu(10'h008);
      rc(8'hA4, 8'hFF, 8'h20);
      rc(8'hA6, 8'hFF, 8'h00);
      chb("adc_result_block", 1'b1, adc_result_block);
      rc(8'hD9, 8'hFF, 8'h00);
      rc(8'hA4, 8'hFF, 8'h00);
      lv = 1'b1;
      rc(8'hA4, 8'hFF, 8'h02);
      lv = 1'b0;
      rc(8'hA4, 8'hFF, 8'h00);
   endtask
   // Bit counter code and count interrupt in both selections
   task t_count;
      core.wr(8'h9A, 8'h00);
      pu(10'h040);
      for (int i = 1; i <= 8; i++)
      begin
         pu(10'h080);
         rc(8'h9A, 8'hF0, {cnt_code[i], 4'h0});
         rc(8'hA4, 8'h04, (i == 8) ? 8'h04 : 8'h00);
      end
      core.wr(8'h9B, 8'h00);
      rc(8'hA4, 8'h04, 8'h00);
      core.wr(8'h9A, 8'h01);
      pu(10'h040);
      pu(10'h080);
      rc(8'hA4, 8'h04, 8'h04);
      rc(8'h9B, 8'hFF, 8'h00);
      rc(8'hA4, 8'h04, 8'h00);
   endtask
   // Two-wire start, stop and stretch control
   task t_twi;
      pu(10'h020);
      rc(8'h9A, 8'h0C, 8'h08);
      rc(8'hA4, 8'h08, 8'h08);
      core.wr(8'h9B, 8'h00);
      rc(8'h9A, 8'h0C, 8'h00);
      rc(8'hA4, 8'h08, 8'h00);
      core.wr(8'h9A, 8'h02);
      chb("stretch_en", 1'b0, stretch_en);
      pu(10'h010);
      rc(8'h9A, 8'h0E, 8'h04);
      chb("stretch_en", 1'b1, stretch_en);
      core.wr(8'h9B, 8'h00);
      rc(8'h9A, 8'h0C, 8'h00);
   endtask
   // SPI pin control, bit order and buffer interrupts
   task t_spi;
      spi_mode = 1'b1;
      core.wr(8'h9A, 8'h03);
      chb("ss_as_gpio", 1'b0, ss_as_gpio);
      chb("sclk_out", 1'b1, sclk_out);
      sclk_act = 1'b1;
      @(negedge clk) chb("sclk_out", 1'b0, sclk_out);
      ss = 1'b1;
      repeat (5) @(negedge clk);
      chb("ser_out_oe_n", 1'b1, ser_out_oe_n);
      ss = 1'b0;
      repeat (4) @(negedge clk);
      chb("ser_out_oe_n", 1'b0, ser_out_oe_n);
      for (int o = 0; o < 2; o++)
      begin
         core.wr(8'h9A, o[0] ? 8'h08 : 8'h00);
         core.wr(8'h9B, 8'hB4);
         pu(10'h040);
         for (int i = 0; i < 8; i++)
         begin
            ser_in = 1'(8'hB4 >> (o[0] ? i : 7 - i));
            chb("ser_out_bit", ser_in, ser_out_bit);
            pu(10'h080);
         end
         pu(10'h100);
         chb("spi_rx_irq", 1'b1, spi_rx_irq);
         rc(8'h9B, 8'hFF, 8'hB4);
         chb("spi_rx_irq", 1'b0, spi_rx_irq);
      end
      // Phase 1: no data at frame start, first bit from the first edge
      core.wr(8'h9A, 8'h04);
      pu(10'h040);
      chb("ser_out_bit", 1'b0, ser_out_bit);
      edg = 1'b1;
      @(negedge clk) edg = 1'b0;
      chb("ser_out_bit", 1'b1, ser_out_bit);
      pu(10'h200);
      chb("spi_tx_irq", 1'b1, spi_tx_irq);
      core.wr(8'h9B, 8'h5A);
      chb("spi_tx_irq", 1'b0, spi_tx_irq);
   endtask
   // Verdict and end of run
   task print_verdict;
      if (mismatches == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      rst = 1'b1;
      spi_mode = 1'b0;
      ser_in = 1'b0;
      sclk_act = 1'b0;
      ss = 1'b1;
      lv = 1'b0;
      edg = 1'b0;
      fl = 6'h00;
      ev = 10'h000;
      repeat (10) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_core();
      t_aux();
      t_count();
      t_twi();
      t_spi();
      print_verdict();
   end
endmodule // serial_port_aux_interrupt_logic_test
